/* File: bsse_core.sv */
`timescale 1ns/1ps
`default_nettype none
module bsse_core
    import bsse_pkg::*;
#(
    parameter int DEPTH = 8
)(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Core state
    output logic      [7:0]  io_out,
    output logic             busy
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam int SP_W = 4;

    typedef struct packed {
        bsse_st_e                st;
        logic                    rdy;
        logic [31:0]             rdat;
        logic                    serr;
        logic                    wok;
        bsse_op_e                op;
        logic                    two;
        bsse_opnd_s              opnd;
        logic [23:0]             pc;
        logic [15:0]             z;
        logic [7:0]              extended_indirect_high_reg;
        logic [7:0]              status_flags_reg;
        logic [7:0]              io;
        logic [7:0]              res;
        logic [2:0]              cnt;
        logic                    tkn;
        logic                    stkerr;
        logic [SP_W-1:0]         sp;
        logic [DEPTH-1:0][23:0]  stk;
    } bsse_r_s;

    bsse_r_s r_q;
    bsse_r_s r_d;

    // Stack pointer must fit SP_W bits
    if (DEPTH < 1 || DEPTH > 15)
    begin : g_chk
        $error("bsse_core: DEPTH must be 1 to 15");
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic f_taken(bsse_op_e op, bsse_opnd_s o,
                                     logic [7:0] s, logic [7:0] io);
        logic t;
        t = 1'b0;
        case (op)
            compare_skip_equal_op:     t = (o.rd == o.rr);
            skip_reg_bit_clear_op:     t = !o.rd[o.bsel];
            skip_reg_bit_set_op:       t = o.rd[o.bsel];
            skip_io_bit_clear_op:      t = !io[o.bsel];
            skip_io_bit_set_op:        t = io[o.bsel];
            branch_flag_set_op:        t = s[o.bsel];
            branch_flag_clear_op:      t = !s[o.bsel];
            branch_carry_set_op:       t = s[F_C];
            branch_carry_clear_op:     t = !s[F_C];
            branch_unsigned_ge_op:     t = !s[F_C];
            branch_unsigned_lt_op:     t = s[F_C];
            branch_signed_ge_op:       t = !(s[F_N] ^ s[F_V]);
            branch_signed_lt_op:       t = s[F_N] ^ s[F_V];
            branch_halfcarry_set_op:   t = s[F_H];
            branch_halfcarry_clear_op: t = !s[F_H];
            branch_overflow_set_op:    t = s[F_V];
            branch_overflow_clear_op:  t = !s[F_V];
            branch_irq_enabled_op:     t = s[F_I];
            branch_irq_disabled_op:    t = !s[F_I];
            default:                   t = 1'b0;
        endcase
        return t;
    endfunction

    function automatic logic f_is_skip(bsse_op_e op);
        return op >= compare_skip_equal_op && op <= skip_io_bit_set_op;
    endfunction

    function automatic logic f_is_br(bsse_op_e op);
        return op >= branch_flag_set_op && op <= branch_irq_disabled_op;
    endfunction

    function automatic logic [2:0] f_cycles(bsse_op_e op, logic t,
                                            logic two);
        logic [2:0] c;
        c = CYC_ONE;
        if (op == indirect_jump_op || op == extended_indirect_jump_op)
        begin
            c = CYC_JMP;
        end
        else if (op == indirect_call_op ||
                 op == extended_indirect_call_op)
        begin
            c = CYC_CALL;
        end
        else if (op == subroutine_return_op || op == interrupt_return_op)
        begin
            c = CYC_RET;
        end
        else if (f_is_skip(op))
        begin
            c = !t ? CYC_ONE : (two ? CYC_SKIP3 : CYC_SKIP2);
        end
        else if (f_is_br(op))
        begin
            c = t ? CYC_BRTK : CYC_ONE;
        end
        else if (op == io_bit_set_op || op == io_bit_clear_op)
        begin
            c = CYC_IO;
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic       setup;
    logic       acc;
    logic       go;
    logic       commit;
    bsse_op_e   wop;
    bsse_opnd_s wopnd;

    assign setup  = psel && !penable;
    assign acc    = psel && penable && r_q.rdy;
    assign go     = acc && pwrite && r_q.wok && paddr == A_CTRL;
    assign commit = r_q.st == ST_EXEC && r_q.cnt == 3'h0;
    assign wop    = bsse_op_e'(pwdata[5:0]);
    assign wopnd  = bsse_opnd_s'(pwdata[25:0]);

    always_comb
    begin
        logic [31:0] rv;
        logic        ok;
        logic        ro;
        logic [7:0]  d;
        logic        t;
        logic [23:0] ret;
        rv  = 32'h0;
        ok  = 1'b1;
        ro  = 1'b0;
        d   = r_q.opnd.rd;
        t   = 1'b0;
        ret = r_q.pc + 24'h1;
        r_d = r_q;

        // Bus answer comes one edge after setup; all writes refused
        // while an instruction runs so operands stay frozen.
        if (paddr == A_CTRL)
        begin
            rv = {23'h0, r_q.two, 2'h0, r_q.op};
        end
        else if (paddr == A_OPND)
        begin
            rv = {6'h0, r_q.opnd};
        end
        else if (paddr == A_PC)
        begin
            rv = {8'h0, r_q.pc};
        end
        else if (paddr == A_ZPTR)
        begin
            rv = {16'h0, r_q.z};
        end
        else if (paddr == A_EXTENDED_INDIRECT_HIGH_REG)
        begin
            rv = {24'h0, r_q.extended_indirect_high_reg};
        end
        else if (paddr == A_STATUS_FLAGS_REG)
        begin
            rv = {24'h0, r_q.status_flags_reg};
        end
        else if (paddr == A_IO)
        begin
            rv = {24'h0, r_q.io};
        end
        else if (paddr == A_RES)
        begin
            rv = {24'h0, r_q.res};
            ro = 1'b1;
        end
        else if (paddr == A_STAT)
        begin
            rv = 32'h0;
            rv[ST_BUSY]   = r_q.st == ST_EXEC;
            rv[ST_TAKEN]  = r_q.tkn;
            rv[ST_STKERR] = r_q.stkerr;
            rv[ST_SP_LSB +: SP_W] = r_q.sp;
            ro = 1'b1;
        end
        else
        begin
            ok = 1'b0;
        end
        if (pwrite && (ro || r_q.st == ST_EXEC))
        begin
            ok = 1'b0;
        end
        if (pwrite && paddr == A_CTRL && pwdata[5:0] > 6'(swap_nibble_op))
        begin
            ok = 1'b0;
        end

        if (setup)
        begin
            r_d.rdy  = 1'b1;
            r_d.rdat = (ok && !pwrite) ? rv : 32'h0;
            r_d.serr = !ok;
            r_d.wok  = ok;
        end
        else if (acc)
        begin
            r_d.rdy  = 1'b0;
            r_d.serr = 1'b0;
        end

        // Register writes
        if (acc && pwrite && r_q.wok)
        begin
            if (paddr == A_OPND)
            begin
                r_d.opnd = wopnd;
            end
            else if (paddr == A_PC)
            begin
                r_d.pc = pwdata[23:0];
            end
            else if (paddr == A_ZPTR)
            begin
                r_d.z = pwdata[15:0];
            end
            else if (paddr == A_EXTENDED_INDIRECT_HIGH_REG)
            begin
                r_d.extended_indirect_high_reg = pwdata[7:0];
            end
            else if (paddr == A_STATUS_FLAGS_REG)
            begin
                r_d.status_flags_reg = pwdata[7:0];
            end
            else if (paddr == A_IO)
            begin
                r_d.io = pwdata[7:0];
            end
        end

        case (r_q.st)
            ST_IDLE:
            begin
                if (go)
                begin
                    r_d.op  = wop;
                    r_d.two = pwdata[CTRL_TWO];
                    r_d.cnt = f_cycles(wop,
                        f_taken(wop, r_q.opnd, r_q.status_flags_reg, r_q.io),
                        pwdata[CTRL_TWO]) - 3'h1;
                    r_d.st  = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                r_d.cnt = r_q.cnt - 3'h1;
                if (commit)
                begin
                    r_d.st = ST_IDLE;
                    t      = f_taken(r_q.op, r_q.opnd, r_q.status_flags_reg, r_q.io);
                    r_d.tkn = t;
                    r_d.pc  = ret;
                    case (r_q.op)
                        indirect_jump_op:
                            r_d.pc = {8'h0, r_q.z};
                        extended_indirect_jump_op:
                            r_d.pc = {r_q.extended_indirect_high_reg, r_q.z};
                        indirect_call_op, extended_indirect_call_op:
                        begin
                            r_d.pc = (r_q.op == indirect_call_op) ?
                                {8'h0, r_q.z} :
                                {r_q.extended_indirect_high_reg, r_q.z};
                            // Full stack keeps the old entries and sets stkerr
                            if (r_q.sp < SP_W'(DEPTH))
                            begin
                                r_d.stk[r_q.sp] = ret;
                                r_d.sp = r_q.sp + SP_W'(1);
                            end
                            else
                            begin
                                r_d.stkerr = 1'b1;
                            end
                        end
                        subroutine_return_op, interrupt_return_op:
                        begin
                            if (r_q.sp != '0)
                            begin
                                r_d.sp = r_q.sp - SP_W'(1);
                                r_d.pc = r_q.stk[r_q.sp - SP_W'(1)];
                            end
                            else
                            begin
                                r_d.stkerr = 1'b1;
                            end
                            if (r_q.op == interrupt_return_op)
                            begin
                                r_d.status_flags_reg[F_I] = 1'b1;
                            end
                        end
                        io_bit_set_op:
                            r_d.io[r_q.opnd.bsel] = 1'b1;
                        io_bit_clear_op:
                            r_d.io[r_q.opnd.bsel] = 1'b0;
                        shift_left_op:
                        begin
                            d = {r_q.opnd.rd[6:0], 1'b0};
                            r_d.status_flags_reg[F_C] = r_q.opnd.rd[7];
                        end
                        shift_right_op:
                        begin
                            d = {1'b0, r_q.opnd.rd[7:1]};
                            r_d.status_flags_reg[F_C] = r_q.opnd.rd[0];
                        end
                        rotate_left_carry_op:
                        begin
                            d = {r_q.opnd.rd[6:0], r_q.status_flags_reg[F_C]};
                            r_d.status_flags_reg[F_C] = r_q.opnd.rd[7];
                        end
                        rotate_right_carry_op:
                        begin
                            d = {r_q.status_flags_reg[F_C], r_q.opnd.rd[7:1]};
                            r_d.status_flags_reg[F_C] = r_q.opnd.rd[0];
                        end
                        swap_nibble_op:
                            d = {r_q.opnd.rd[3:0], r_q.opnd.rd[7:4]};
                        default:
                        begin
                            if (t && f_is_skip(r_q.op))
                            begin
                                r_d.pc = r_q.pc + (r_q.two ? 24'h3 : 24'h2);
                            end
                            else if (t && f_is_br(r_q.op))
                            begin
                                r_d.pc = ret + {{17{r_q.opnd.k[6]}},
                                                r_q.opnd.k};
                            end
                        end
                    endcase
                    if (r_q.op >= shift_left_op &&
                        r_q.op <= rotate_right_carry_op)
                    begin
                        r_d.status_flags_reg[F_Z] = d == 8'h0;
                        r_d.status_flags_reg[F_N] = d[7];
                        r_d.status_flags_reg[F_V] = d[7] ^ r_d.status_flags_reg[F_C];
                    end
                    if (r_q.op >= shift_left_op)
                    begin
                        r_d.res = d;
                    end
                end
            end
            default:
                r_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_q    <= '0;
            r_q.st <= ST_IDLE;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign prdata  = r_q.rdat;
    assign pready  = r_q.rdy;
    assign pslverr = r_q.serr;
    assign io_out  = r_q.io;
    assign busy    = r_q.st == ST_EXEC;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_indirect_jump_op_two_cyc: assert property (
        @(posedge pclk) disable iff (!presetn)
        go && wop == indirect_jump_op |=> busy [*2] ##1 !busy
        && r_q.pc == {8'h0, $past(r_q.z)})
        else $error("indirect jump timing or target wrong");

    a_extended_indirect_jump_op_dest: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && r_q.op == extended_indirect_jump_op
        |=> r_q.pc == {$past(r_q.extended_indirect_high_reg), $past(r_q.z)})
        else $error("extended jump target wrong");

    a_call_four: assert property (
        @(posedge pclk) disable iff (!presetn)
        go && (wop == indirect_call_op || wop == extended_indirect_call_op)
        |=> busy [*4] ##1 !busy)
        else $error("call did not take four cycles");

    a_skip_dist: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && f_is_skip(r_q.op) &&
        f_taken(r_q.op, r_q.opnd, r_q.status_flags_reg, r_q.io)
        |=> r_q.pc == $past(r_q.pc) + ($past(r_q.two) ? 24'h3 : 24'h2))
        else $error("skip distance wrong");

    a_branch_tgt: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && f_is_br(r_q.op) &&
        !f_taken(r_q.op, r_q.opnd, r_q.status_flags_reg, r_q.io)
        |=> r_q.pc == $past(r_q.pc) + 24'h1 && !r_q.tkn)
        else $error("untaken branch moved too far");

    a_signed_ge_cond: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && r_q.op == branch_signed_ge_op
        |=> r_q.tkn == !($past(r_q.status_flags_reg[F_N]) ^ $past(r_q.status_flags_reg[F_V])))
        else $error("signed branch condition wrong");

    a_io_bit_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        go && wop == io_bit_set_op |=> ##2 r_q.io[r_q.opnd.bsel]
        && $stable(r_q.status_flags_reg))
        else $error("io bit set failed");

    a_lsl_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && r_q.op == shift_left_op |=> r_q.res[0] == 1'b0 &&
        r_q.status_flags_reg[F_C] == $past(r_q.opnd.rd[7]) &&
        r_q.status_flags_reg[F_Z] == (r_q.res == 8'h0))
        else $error("shift left result or flags wrong");

    a_ror_carry: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && r_q.op == rotate_right_carry_op |=>
        r_q.res[7] == $past(r_q.status_flags_reg[F_C]) &&
        r_q.status_flags_reg[F_C] == $past(r_q.opnd.rd[0]))
        else $error("rotate right through carry wrong");

    a_swap_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        go && wop == swap_nibble_op |=> busy ##1 !busy &&
        $stable(r_q.status_flags_reg) && r_q.res[3:0] == r_q.opnd.rd[7:4])
        else $error("swap wrong");

    a_interrupt_return_op_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && r_q.op == interrupt_return_op |=> r_q.status_flags_reg[F_I])
        else $error("interrupt return left I clear");

endmodule
`default_nettype wire

/* File: bsse_pkg.sv */
`default_nettype none
package bsse_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_OPND = 8'h04;
    localparam logic [7:0] A_PC   = 8'h08;
    localparam logic [7:0] A_ZPTR = 8'h0C;
    localparam logic [7:0] A_EXTENDED_INDIRECT_HIGH_REG = 8'h10;
    localparam logic [7:0] A_STATUS_FLAGS_REG = 8'h14;
    localparam logic [7:0] A_IO   = 8'h18;
    localparam logic [7:0] A_RES  = 8'h1C;
    localparam logic [7:0] A_STAT = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_TWO  = 8;
    localparam int ST_BUSY   = 0;
    localparam int ST_TAKEN  = 1;
    localparam int ST_STKERR = 2;
    localparam int ST_SP_LSB = 8;
    localparam int F_C = 0;
    localparam int F_Z = 1;
    localparam int F_N = 2;
    localparam int F_V = 3;
    localparam int F_H = 5;
    localparam int F_I = 7;

    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam logic [2:0] CYC_ONE   = 3'h1;
    localparam logic [2:0] CYC_JMP   = 3'h2;
    localparam logic [2:0] CYC_CALL  = 3'h4;
    localparam logic [2:0] CYC_RET   = 3'h5;
    localparam logic [2:0] CYC_SKIP2 = 3'h2;
    localparam logic [2:0] CYC_SKIP3 = 3'h3;
    localparam logic [2:0] CYC_BRTK  = 3'h2;
    localparam logic [2:0] CYC_IO    = 3'h2;

    // ------------------------------------------------------------
    // Operations and carriers
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        indirect_jump_op, extended_indirect_jump_op, indirect_call_op,
        extended_indirect_call_op, subroutine_return_op,
        interrupt_return_op, compare_skip_equal_op, skip_reg_bit_clear_op,
        skip_reg_bit_set_op, skip_io_bit_clear_op, skip_io_bit_set_op,
        branch_flag_set_op, branch_flag_clear_op, branch_carry_set_op,
        branch_carry_clear_op, branch_unsigned_ge_op, branch_unsigned_lt_op,
        branch_signed_ge_op, branch_signed_lt_op, branch_halfcarry_set_op,
        branch_halfcarry_clear_op, branch_overflow_set_op,
        branch_overflow_clear_op, branch_irq_enabled_op,
        branch_irq_disabled_op, io_bit_set_op, io_bit_clear_op,
        shift_left_op, shift_right_op, rotate_left_carry_op,
        rotate_right_carry_op, swap_nibble_op
    } bsse_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } bsse_st_e;

    typedef struct packed {
        logic [6:0] k;
        logic [2:0] bsel;
        logic [7:0] rr;
        logic [7:0] rd;
    } bsse_opnd_s;

endpackage
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import bsse_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and case table
    // ------------------------------------------------------------
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  io_out;
    logic        busy;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  a;
    int          n;
    int          miscompares = 0;
    int          checks_done = 0;
    typedef struct {
        logic [5:0]  op;
        logic        two;
        logic [25:0] opnd;
        logic [7:0]  sr;
        logic [23:0] exp;
        logic [7:0]  esr;
        int          cyc;
    } bsse_row_s;
    // Every row starts at PC 0x10, Z 0x1234, high reg 0x05, IO 0xA5
    bsse_row_s rows[34] = '{
        '{6'h00, 1'h0, 26'h0, 8'h00, 24'h001234, 8'h00, 2},
        '{6'h01, 1'h0, 26'h0, 8'h00, 24'h051234, 8'h00, 2},
        '{6'h02, 1'h0, 26'h0, 8'h00, 24'h001234, 8'h00, 4},
        '{6'h03, 1'h0, 26'h0, 8'h00, 24'h051234, 8'h00, 4},
        '{6'h04, 1'h0, 26'h0, 8'h00, 24'h000011, 8'h00, 5},
        '{6'h05, 1'h0, 26'h0, 8'h00, 24'h000011, 8'h80, 5},
        '{6'h06, 1'h0, 26'h3333, 8'h00, 24'h12, 8'h00, 2},
        '{6'h06, 1'h0, 26'h3334, 8'h00, 24'h11, 8'h00, 1},
        '{6'h07, 1'h0, 26'h10101, 8'h00, 24'h12, 8'h00, 2},
        '{6'h08, 1'h0, 26'h00101, 8'h00, 24'h12, 8'h00, 2},
        '{6'h09, 1'h0, 26'h10000, 8'h00, 24'h12, 8'h00, 2},
        '{6'h0A, 1'h1, 26'h0, 8'h00, 24'h13, 8'h00, 3},
        '{6'h0B, 1'h0, 26'h180000, 8'h01, 24'h14, 8'h01, 2},
        '{6'h0C, 1'h0, 26'h3F00000, 8'h00, 24'h0F, 8'h00, 2},
        '{6'h0D, 1'h0, 26'h180000, 8'h00, 24'h11, 8'h00, 1},
        '{6'h0E, 1'h0, 26'h180000, 8'h00, 24'h14, 8'h00, 2},
        '{6'h0F, 1'h0, 26'h180000, 8'h01, 24'h11, 8'h01, 1},
        '{6'h10, 1'h0, 26'h180000, 8'h01, 24'h14, 8'h01, 2},
        '{6'h11, 1'h0, 26'h180000, 8'h0C, 24'h14, 8'h0C, 2},
        '{6'h12, 1'h0, 26'h180000, 8'h04, 24'h14, 8'h04, 2},
        '{6'h13, 1'h0, 26'h180000, 8'h20, 24'h14, 8'h20, 2},
        '{6'h14, 1'h0, 26'h180000, 8'h20, 24'h11, 8'h20, 1},
        '{6'h15, 1'h0, 26'h180000, 8'h08, 24'h14, 8'h08, 2},
        '{6'h16, 1'h0, 26'h180000, 8'h08, 24'h11, 8'h08, 1},
        '{6'h17, 1'h0, 26'h180000, 8'h80, 24'h14, 8'h80, 2},
        '{6'h18, 1'h0, 26'h180000, 8'h80, 24'h11, 8'h80, 1},
        '{6'h19, 1'h0, 26'h10000, 8'h00, 24'hA7, 8'h00, 2},
        '{6'h1A, 1'h0, 26'h0, 8'h00, 24'hA4, 8'h00, 2},
        '{6'h1B, 1'h0, 26'h81, 8'h00, 24'h02, 8'h09, 1},
        '{6'h1C, 1'h0, 26'h01, 8'h00, 24'h00, 8'h0B, 1},
        '{6'h1D, 1'h0, 26'h80, 8'h01, 24'h01, 8'h09, 1},
        '{6'h1E, 1'h0, 26'h01, 8'h01, 24'h80, 8'h05, 1},
        '{6'h1F, 1'h0, 26'h3C, 8'h2F, 24'hC3, 8'h2F, 1},
        '{6'h04, 1'h0, 26'h0, 8'h00, 24'h11, 8'h00, 5}
    };
    bsse_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .io_out(io_out), .busy(busy));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Request held until pready is sampled high, released only after it
    task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wait_idle();
        n = 0;
        #1;
        while (busy === 1'h1 && n < 20)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (busy !== 1'h0)
            miscompares++;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end
    // Whole sequence needs about 840 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        print_verdict();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        chk("io_out at reset", {24'h0, io_out}, 32'h0);
        apb(1'h1, A_ZPTR, 32'h1234);
        apb(1'h1, A_EXTENDED_INDIRECT_HIGH_REG, 32'h05);
        foreach (rows[i])
        begin
            apb(1'h1, A_PC, 32'h10);
            apb(1'h1, A_IO, 32'hA5);
            apb(1'h1, A_STATUS_FLAGS_REG, {24'h0, rows[i].sr});
            apb(1'h1, A_OPND, {6'h0, rows[i].opnd});
            apb(1'h1, A_CTRL, {23'h0, rows[i].two, 2'h0, rows[i].op});
            wait_idle();
            chk("cycles", n, rows[i].cyc);
            a = (rows[i].op >= 6'h1B) ? A_RES :
                (rows[i].op >= 6'h19) ? A_IO : A_PC;
            apb(1'h0, a, 32'h0);
            chk("result", rd, {8'h0, rows[i].exp});
            apb(1'h0, A_STATUS_FLAGS_REG, 32'h0);
            chk("flags", rd, {24'h0, rows[i].esr});
        end
        chk("io pin", {24'h0, io_out}, 32'hA5);
        apb(1'h0, A_STAT, 32'h0);
        chk("stack state", rd & 32'hF04, 32'h4);
        apb(1'h0, 8'h24, 32'h0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        apb(1'h1, A_CTRL, 32'h20);
        chk("bad op", {31'h0, err}, 32'h1);
        apb(1'h1, A_CTRL, 32'h02);
        apb(1'h1, A_PC, 32'h55);
        chk("write while busy", {31'h0, err}, 32'h1);
        wait_idle();
        apb(1'h0, A_PC, 32'h0);
        chk("call target", rd, 32'h1234);
        // Reset in mid-instruction must drop busy and clear all state
        apb(1'h1, A_CTRL, 32'h02);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        chk("busy in reset", {31'h0, busy}, 32'h0);
        chk("pready in reset", {31'h0, pready}, 32'h0);
        chk("io in reset", {24'h0, io_out}, 32'h0);
        presetn <= 1'h1;
        apb(1'h0, A_PC, 32'h0);
        chk("pc after reset", rd, 32'h0);
        apb(1'h0, A_STAT, 32'h0);
        chk("stat after reset", rd, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
